// ---- hw/sep_eeprom.sv ----
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - straps form address bits one to three
// - input bits sampled on clock rising edge
// - output data changes on clock falling edge
// - data line only pulled low or released
// - write protect high blocks array writes
// - undriven straps and protect read low
// - array of 4096 bytes, twelve-bit address
// - page write up to 32 bytes
// - partial page writes only touch sent bytes
// - random and incrementing sequential reads
// - self-timed programming within 5 ms
// - address byte needs type pattern 1010
// - msb first, ninth clock carries acknowledge
// - start and stop from data edges
// - master nack ends read, line released
module sep_eeprom #(
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES_DEF
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_addr_strap_lo_i,
  input wire logic slave_addr_strap_mid_i,
  input wire logic slave_addr_strap_hi_i,
  input wire logic wp_i
);

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);
  localparam logic [CW-1:0] PAGE_CNT = CW'(sep_pkg::PAGE_BYTES);

  // walking the page must fit inside the programming time
  if (PROG_CYCLES < sep_pkg::PAGE_BYTES + 1) begin : g_bad_prog
    $error("sep_eeprom: PROG_CYCLES too small for one page walk");
  end

  // ************************************************************
  // pin synchronisers and bus conditions
  // ************************************************************
  logic [sep_pkg::PIN_W-1:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] strap_s;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // undriven strap and protect pads are pulled down outside, so a float reads low
  sep_sync #(
    .WIDTH(sep_pkg::PIN_W),
    .RST_VAL(sep_pkg::PIN_RST_VAL)
  ) u_sync (
    .clk_i(mclk_i),
    .rst_i(sys_rst_i),
    .d_i({scl_i, sda_i, slave_addr_strap_hi_i, slave_addr_strap_mid_i,
          slave_addr_strap_lo_i, wp_i}),
    .q_o(pin_s)
  );

  assign scl_s = pin_s[sep_pkg::PIN_SCL];
  assign sda_s = pin_s[sep_pkg::PIN_SDA];
  assign wp_s = pin_s[sep_pkg::PIN_WP];
  assign strap_s = pin_s[sep_pkg::PIN_STRAP_HI:sep_pkg::PIN_STRAP_LO];

  // previous levels for edge detection; reset as an idle bus
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // data moving while clock stays high frames a transfer
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ************************************************************
  // protocol engine
  // ************************************************************
  sep_pkg::sep_state_t state_r, state_nxt;
  sep_pkg::sep_phase_t phase_r, phase_nxt;
  logic [sep_pkg::BIT_CNT_W-1:0] bitcnt_r, bitcnt_nxt;
  logic [sep_pkg::DATA_W-1:0] sh_r, sh_nxt;
  logic [sep_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic oe_r, oe_nxt;
  logic sda_o_r;
  logic [sep_pkg::PAGE_BYTES-1:0] mask_r, mask_nxt;
  logic [sep_pkg::DATA_W-1:0] page_buf_r [sep_pkg::PAGE_BYTES];
  logic buf_we;
  logic dev_ack;
  logic dev_match;
  logic ack_ok;
  logic prog_go;
  logic prog_end;
  logic busy_r, busy_nxt;
  logic [CW-1:0] pcnt_r, pcnt_nxt;
  logic [sep_pkg::DATA_W-1:0] rdata;

  assign dev_match = (sh_r[7:sep_pkg::DEV_TYPE_POS] == sep_pkg::DEV_TYPE)
                   && (sh_r[sep_pkg::STRAP_POS +: 3] == strap_s);
  assign prog_end = busy_r && (pcnt_r == PROG_LAST);

  // next state of the serial engine; start and stop override any state
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    bitcnt_nxt = bitcnt_r;
    sh_nxt = sh_r;
    addr_nxt = addr_r;
    oe_nxt = oe_r;
    mask_nxt = mask_r;
    buf_we = 1'b0;
    dev_ack = 1'b0;
    prog_go = 1'b0;
    ack_ok = 1'b0;
    if (prog_end) begin
      mask_nxt = '0;
    end
    if (start_det) begin
      state_nxt = sep_pkg::ST_RX;
      phase_nxt = sep_pkg::PH_DEV;
      bitcnt_nxt = '0;
      oe_nxt = 1'b0;
      // a fresh transfer discards a page that never saw a stop
      if (!busy_r) begin
        mask_nxt = '0;
      end
    end else if (stop_det) begin
      state_nxt = sep_pkg::ST_IDLE;
      oe_nxt = 1'b0;
      prog_go = !busy_r && (|mask_r) && !wp_s;
    end else begin
      case (state_r)
        sep_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == sep_pkg::BYTE_BITS) begin
            case (phase_r)
              sep_pkg::PH_DEV: ack_ok = dev_match && !busy_r;
              sep_pkg::PH_DATA: ack_ok = !wp_s;
              default: ack_ok = 1'b1;
            endcase
            if (ack_ok) begin
              oe_nxt = 1'b1;
              state_nxt = sep_pkg::ST_ACK;
              case (phase_r)
                sep_pkg::PH_DEV: dev_ack = 1'b1;
                sep_pkg::PH_AHI: addr_nxt[11:8] = sh_r[3:0];
                sep_pkg::PH_ALO: addr_nxt[7:0] = sh_r;
                default: begin
                  // data wraps inside the page, never into the next
                  buf_we = 1'b1;
                  mask_nxt[addr_r[4:0]] = 1'b1;
                  addr_nxt[4:0] = addr_r[4:0] + 5'h01;
                end
              endcase
            end else begin
              // no acknowledge: stay off the line until the next start
              state_nxt = sep_pkg::ST_IDLE;
            end
          end
        end
        sep_pkg::ST_ACK: begin
          if (scl_fall) begin
            bitcnt_nxt = '0;
            if (phase_r == sep_pkg::PH_DEV && sh_r[sep_pkg::RW_POS]) begin
              state_nxt = sep_pkg::ST_TX;
              sh_nxt = rdata;
              oe_nxt = ~rdata[7];
            end else begin
              oe_nxt = 1'b0;
              state_nxt = sep_pkg::ST_RX;
              case (phase_r)
                sep_pkg::PH_DEV: phase_nxt = sep_pkg::PH_AHI;
                sep_pkg::PH_AHI: phase_nxt = sep_pkg::PH_ALO;
                default: phase_nxt = sep_pkg::PH_DATA;
              endcase
            end
          end
        end
        sep_pkg::ST_TX: begin
          if (scl_rise) begin
            bitcnt_nxt = bitcnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_r == sep_pkg::BYTE_BITS) begin
              oe_nxt = 1'b0;
              state_nxt = sep_pkg::ST_MACK;
              addr_nxt = addr_r + 12'h001;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        sep_pkg::ST_MACK: begin
          if (scl_rise) begin
            sh_nxt[0] = sda_s;
          end else if (scl_fall) begin
            bitcnt_nxt = '0;
            if (!sh_r[0]) begin
              state_nxt = sep_pkg::ST_TX;
              sh_nxt = rdata;
              oe_nxt = ~rdata[7];
            end else begin
              state_nxt = sep_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_nxt = sep_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // engine registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r <= sep_pkg::ST_IDLE;
      phase_r <= sep_pkg::PH_DEV;
      bitcnt_r <= '0;
      sh_r <= '0;
      addr_r <= '0;
      oe_r <= 1'b0;
      sda_o_r <= 1'b0;
      mask_r <= '0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      bitcnt_r <= bitcnt_nxt;
      sh_r <= sh_nxt;
      addr_r <= addr_nxt;
      oe_r <= oe_nxt;
      sda_o_r <= 1'b0;
      mask_r <= mask_nxt;
    end
  end

  // page latch; the mask, not the contents, says what gets programmed
  always_ff @(posedge mclk_i) begin
    if (buf_we) begin
      page_buf_r[addr_r[4:0]] <= sh_r;
    end
  end

  // ************************************************************
  // self-timed programming
  // ************************************************************
  // one counter both walks the page and times the whole cycle
  always_comb begin
    busy_nxt = busy_r;
    pcnt_nxt = pcnt_r;
    if (prog_go) begin
      busy_nxt = 1'b1;
      pcnt_nxt = '0;
    end else if (busy_r) begin
      if (prog_end) begin
        busy_nxt = 1'b0;
      end else begin
        pcnt_nxt = pcnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
      pcnt_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end

  logic mem_we;
  assign mem_we = busy_r && (pcnt_r < PAGE_CNT)
                && mask_r[pcnt_r[4:0]];

  sep_mem u_mem (
    .clk_i(mclk_i),
    .we_i(mem_we),
    .waddr_i({addr_r[11:5], pcnt_r[4:0]}),
    .wdata_i(page_buf_r[pcnt_r[4:0]]),
    .raddr_i(addr_r),
    .rdata_o(rdata)
  );

  assign sda_o = sda_o_r;
  assign sda_oe_o = oe_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  strap_match_a: assert property (dev_ack |-> sh_r[3:1] == strap_s)
    else $error("address acknowledged with wrong strap bits");
  dev_type_a: assert property (dev_ack |-> sh_r[7:4] == 4'hA)
    else $error("address acknowledged with wrong type pattern");
  rise_sample_a: assert property (($past(state_r) == sep_pkg::ST_RX
      && state_r == sep_pkg::ST_RX && $changed(sh_r)) |-> $past(scl_rise))
    else $error("receive shift moved without a clock rise");
  fall_drive_a: assert property ($changed(oe_r) |->
      $past(scl_fall || start_det || stop_det))
    else $error("data line changed away from a clock fall");
  drive_low_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  wp_block_a: assert property ((prog_go || buf_we) |-> !wp_s)
    else $error("write taken while protected");
  page_stay_a: assert property (buf_we |=> addr_r[11:5] == $past(addr_r[11:5])
      && addr_r[4:0] == $past(addr_r[4:0]) + 5'h01)
    else $error("page address left its page");
  read_inc_a: assert property ($rose(state_r == sep_pkg::ST_MACK)
      |-> addr_r == $past(addr_r) + 12'h001)
    else $error("sequential read address did not step");
  prog_time_a: assert property (prog_go |=> busy_r [*8])
    else $error("programming ended early");
  prog_bound_a: assert property (busy_r |-> pcnt_r <= PROG_LAST)
    else $error("programming counter past its limit");
  // watch the pin itself: the acknowledge gate alone would hold by design
  busy_nack_a: assert property ((busy_r && state_r == sep_pkg::ST_RX
      && phase_r == sep_pkg::PH_DEV && scl_fall && bitcnt_r == 4'h8
      && !start_det && !stop_det) |=> !oe_r)
    else $error("address acknowledged while programming");
  nack_release_a: assert property ((state_r == sep_pkg::ST_MACK && scl_fall
      && sh_r[0] && !start_det && !stop_det) |=> !oe_r
      && state_r == sep_pkg::ST_IDLE)
    else $error("line not released after master nack");
  start_rx_a: assert property (start_det |=> state_r == sep_pkg::ST_RX
      && bitcnt_r == 4'h0)
    else $error("start did not open a receive");

  prog_cov_c: cover property (prog_go);
  read_cov_c: cover property (state_r == sep_pkg::ST_MACK && scl_fall
      && !sh_r[0]);
  busy_cov_c: cover property (busy_r && state_r == sep_pkg::ST_RX
      && scl_fall && bitcnt_r == 4'h8 && phase_r == sep_pkg::PH_DEV);
  wp_cov_c: cover property (wp_s && state_r == sep_pkg::ST_RX && scl_fall
      && bitcnt_r == 4'h8 && phase_r == sep_pkg::PH_DATA);

endmodule : sep_eeprom

`default_nettype wire

// ---- hw/sep_pkg.sv ----
package sep_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_IDX_W = 5;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ************************************************************
  // address byte layout
  // ************************************************************
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int DEV_TYPE_POS = 4;
  localparam int STRAP_POS = 1;
  localparam int RW_POS = 0;

  // ************************************************************
  // pin synchroniser layout and reset levels
  // ************************************************************
  localparam int PIN_W = 6;
  localparam int PIN_SCL = 5;
  localparam int PIN_SDA = 4;
  localparam int PIN_STRAP_HI = 3;
  localparam int PIN_STRAP_MID = 2;
  localparam int PIN_STRAP_LO = 1;
  localparam int PIN_WP = 0;
  localparam logic [5:0] PIN_RST_VAL = 6'h30;

  // ************************************************************
  // self-timed programming
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_NS = 5000000;
  // longest time, so the division rounds down
  localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

  // ************************************************************
  // protocol states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_TX = 3'h3,
    ST_MACK = 3'h4
  } sep_state_t;

  typedef enum logic [1:0] {
    PH_DEV = 2'h0,
    PH_AHI = 2'h1,
    PH_ALO = 2'h2,
    PH_DATA = 2'h3
  } sep_phase_t;

endpackage : sep_pkg

// ---- hw/sep_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module sep_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // two stages; only the second stage is seen outside
  always_comb begin
    meta_nxt = d_i;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule : sep_sync

`default_nettype wire

// ---- hw/sep_mem.sv ----
`timescale 1ns/100ps
`default_nettype none

module sep_mem #(
  parameter int DEPTH = sep_pkg::MEM_DEPTH,
  parameter int AW = sep_pkg::ADDR_W,
  parameter int DW = sep_pkg::DATA_W
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("sep_mem: depth must equal two to the address width");
  end

  // non-volatile array: no reset, contents survive protocol resets
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] rdata_r;

  // registered read; the address is stable long before a bit goes out
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_r <= mem_r[raddr_i];
  end

  assign rdata_o = rdata_r;

endmodule : sep_mem

`default_nettype wire

// ---- dv/sep_master.sv ----
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// two-wire bus master model
// ************************************************************
module sep_master (
  input wire logic mclk_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_oe_o
);
  // idle bus: clock stands high, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : hold

  // data moves mid-low so it is steady well before the rising clock
  task automatic put_bit(input logic b, output logic smp);
    hold(4);
    sda_oe_o = ~b;
    hold(4);
    scl_o = 1'b1;
    hold(8);
    smp = sda_i;
    scl_o = 1'b0;
  endtask : put_bit

  // repeated start first raises the clock with data released
  task automatic start();
    if (scl_o === 1'b0) begin
      hold(4);
      sda_oe_o = 1'b0;
      hold(4);
      scl_o = 1'b1;
      hold(8);
    end
    sda_oe_o = 1'b1;
    hold(8);
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    hold(4);
    sda_oe_o = 1'b1;
    hold(4);
    scl_o = 1'b1;
    hold(8);
    sda_oe_o = 1'b0;
    hold(8);
  endtask : stop

  // msb first, then the ninth clock carries the answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], smp);
    end
    put_bit(1'b1, smp);
    ack = ~smp;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, smp);
      b[i] = smp;
    end
    put_bit(~ack, smp);
  endtask : recv_byte
endmodule : sep_master

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// eeprom slave testbench
// ************************************************************
module testbench;
  localparam int PROG = 400;
  localparam logic [2:0] STRAP = 3'h5;
  logic mclk, sys_rst, scl, m_oe, sda_o, d_oe, wp_drv;
  logic [2:0] strap;
  logic [7:0] q[$];
  int fail_count, n_checks;
  wire logic sda_w;
  tri0 wp_w;

  // open-drain wire: anyone pulling low wins over the pull-up
  assign sda_w = ~m_oe & (~d_oe | sda_o);
  // a floating protect pin falls to the pad pull-down
  assign wp_w = wp_drv;

  sep_eeprom #(.PROG_CYCLES(PROG)) sep_eeprom_i (
    .mclk_i(mclk), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(d_oe), .slave_addr_strap_lo_i(strap[0]),
    .slave_addr_strap_mid_i(strap[1]), .slave_addr_strap_hi_i(strap[2]),
    .wp_i(wp_w));
  sep_master sep_master_i (.mclk_i(mclk), .sda_i(sda_w), .scl_o(scl),
    .sda_oe_o(m_oe));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check_bit(input logic act, input logic exp);
    n_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check_bit

  task automatic check_byte(input logic [7:0] act, input logic [7:0] exp);
    n_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check_byte

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  function automatic logic [7:0] dev_byte(input logic rw);
    return {sep_pkg::DEV_TYPE, STRAP, rw};
  endfunction : dev_byte

  task automatic set_addr(input logic [11:0] a);
    logic ack;
    sep_master_i.start();
    sep_master_i.send_byte(dev_byte(1'b0), ack);
    check_bit(ack, 1'b1);
    sep_master_i.send_byte({4'h0, a[11:8]}, ack);
    check_bit(ack, 1'b1);
    sep_master_i.send_byte(a[7:0], ack);
    check_bit(ack, 1'b1);
  endtask : set_addr

  task automatic write_run(input logic [11:0] a, input logic [7:0] base,
                           input int n, input logic ack_exp);
    logic ack;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      sep_master_i.send_byte(base + i[7:0], ack);
      check_bit(ack, ack_exp);
    end
    sep_master_i.stop();
  endtask : write_run

  // random read, then a sequential run; the last byte is refused
  task automatic read_seq(input logic [11:0] a, input logic [7:0] exp[$]);
    logic ack;
    logic [7:0] d;
    set_addr(a);
    sep_master_i.start();
    sep_master_i.send_byte(dev_byte(1'b1), ack);
    check_bit(ack, 1'b1);
    foreach (exp[i]) begin
      sep_master_i.recv_byte(i != exp.size() - 1, d);
      check_byte(d, exp[i]);
    end
    repeat (8) @(negedge mclk);
    check_bit(d_oe, 1'b0);
    sep_master_i.stop();
  endtask : read_seq

  // poll by address byte; four polls span more than one write cycle
  task automatic wait_ready(input logic busy_first);
    logic ack;
    logic [7:0] d;
    ack = 1'b0;
    for (int i = 0; i < 4 && !ack; i++) begin
      sep_master_i.start();
      sep_master_i.send_byte(dev_byte(1'b1), ack);
      if (i == 0 && busy_first) check_bit(ack, 1'b0);
      if (ack) sep_master_i.recv_byte(1'b0, d);
      sep_master_i.stop();
    end
    check_bit(ack, 1'b1);
  endtask : wait_ready

  // every other strap value and a wrong type nibble stay unanswered
  task automatic wrong_addr();
    logic ack;
    for (int s = 0; s < 9; s++) begin
      if (s[2:0] != STRAP || s == 8) begin
        sep_master_i.start();
        sep_master_i.send_byte(s < 8 ? {sep_pkg::DEV_TYPE, s[2:0], 1'b0}
                               : {4'hB, STRAP, 1'b0}, ack);
        check_bit(ack, 1'b0);
        sep_master_i.stop();
      end
    end
  endtask : wrong_addr

  // the data pin may only ever be pulled low
  always @(negedge mclk) begin
    if (d_oe === 1'b1) check_bit(sda_o, 1'b0);
  end

  // about five times the expected run length
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    wp_drv = 1'b0;
    strap = STRAP;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    wp_drv = 1'bz;
    write_run(12'hF40, 8'h40, 32, 1'b1);
    wait_ready(1'b1);
    write_run(12'hF5E, 8'hC0, 3, 1'b1);
    wait_ready(1'b1);
    read_seq(12'hF5E, '{8'hC0, 8'hC1});
    q.push_back(8'hC2);
    for (int i = 1; i < 30; i++) q.push_back(8'h40 + i[7:0]);
    read_seq(12'hF40, q);
    wp_drv = 1'b1;
    write_run(12'hF41, 8'hAA, 1, 1'b0);
    wait_ready(1'b0);
    wp_drv = 1'b0;
    read_seq(12'hF41, '{8'h41});
    wrong_addr();
    read_seq(12'hF5F, '{8'hC1});
    complete_run();
  end
endmodule : testbench

`default_nettype wire
